// >>> core/bfdr_pkg.sv
// Shared constants and carrier types for the bridge fault supervisor.
// Assumes a single 25 MHz clock and a 32-bit APB register bus.
package bfdr_pkg;

	localparam int CLK_HZ = 25_000_000;
	localparam int ISD_FILT_NS = 1000;
	localparam int RECHK_NS = 3250;
	localparam int RECOV_TMO_MS = 300;
	// Least times round up to whole cycles.
	localparam int ISD_CYC = (ISD_FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int CHK_CYC = (RECHK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int RECOV_TMO_CYC = RECOV_TMO_MS * (CLK_HZ / 1000);
	localparam int ISD_W = $clog2(ISD_CYC + 1);
	localparam int CHK_W = $clog2(CHK_CYC + 1);

	localparam int ADDR_W = 8;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] REL_OFS = 8'h08;

	localparam int CTRL_LATCHED = 0;
	localparam int CTRL_SPI_PWM0 = 1;
	localparam int CTRL_SPI_PWM1 = 2;
	localparam int CTRL_HALF = 3;

	localparam int STAT_OC0 = 0;
	localparam int STAT_OC1 = 1;
	localparam int STAT_OT = 2;
	localparam int STAT_VBAT_UV = 3;
	localparam int STAT_VCC_UV = 4;
	localparam int STAT_OPEN0 = 5;
	localparam int STAT_OPEN1 = 6;
	localparam int STAT_LVUV = 10;

	typedef struct packed {
		logic latched;
		logic [1:0] spi_pwm;
		logic half_bridge;
	} bfdr_ctrl_t;

	localparam bfdr_ctrl_t CTRL_RST = '0;

	typedef enum logic [1:0] {
		BFDR_REG_CTRL = 2'b00,
		BFDR_REG_STAT = 2'b01,
		BFDR_REG_REL = 2'b10,
		BFDR_REG_NONE = 2'b11
	} bfdr_reg_t;

endpackage

// >>> core/bfdr_chan.sv
// One bridge channel: over-current filter, tri-state, recovery and re-check.
// Assumes enable edges and release commands arrive as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module bfdr_chan #(
	parameter int TMO_CYC = bfdr_pkg::RECOV_TMO_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Mode
	input wire logic latched_mode,
	input wire logic spi_pwm,
	input wire logic half_bridge,
	// Events
	input wire logic [1:0] oc_raw,
	input wire logic enabled,
	input wire logic en_edge,
	input wire logic pin_edge,
	input wire logic rel_cmd,
	input wire logic duty_on,
	// Results
	output logic [1:0] hiz,
	output logic oc_stat,
	output logic fault_pin_n_low
);
	import bfdr_pkg::*;

	localparam int TW = $clog2(TMO_CYC + 1);

	typedef struct packed {
		logic [1:0][ISD_W-1:0] filt;
		logic [1:0] hiz;
		logic pend;
		logic tmo_run;
		logic [TW-1:0] tmo;
		logic chk_run;
		logic [CHK_W-1:0] chk;
		logic oc_stat;
		logic fault_pin_n_low;
	} bfdr_chan_t;

	bfdr_chan_t s;
	bfdr_chan_t next_s;
	logic [1:0] trip;
	logic tmo_done;
	logic rel_ok;

	always_comb begin
		next_s = s;
		trip = 2'b00;
		for (int i = 0; i < 2; i++) begin
			if (!oc_raw[i] || s.hiz[i]) begin
				next_s.filt[i] = '0;
			end else if (s.filt[i] == ISD_W'(ISD_CYC - 1)) begin
				trip[i] = 1'b1;
			end else begin
				next_s.filt[i] = s.filt[i] + 1'b1;
			end
		end
		// A latched channel never times out.
		tmo_done = s.tmo_run && !latched_mode &&
			s.tmo == TW'(TMO_CYC - 1);
		if (s.tmo_run && s.tmo != TW'(TMO_CYC - 1)) begin
			next_s.tmo = s.tmo + 1'b1;
		end
		if (en_edge || rel_cmd || tmo_done) begin
			next_s.tmo_run = 1'b0;
		end
		// While disabled only the enabling edge may release.
		rel_ok = en_edge || (enabled && (rel_cmd || tmo_done));
		if (|s.hiz) begin
			if (rel_ok && spi_pwm && !half_bridge && !en_edge) begin
				next_s.pend = 1'b1;
			end else if (rel_ok || (s.pend && duty_on && enabled)) begin
				next_s.hiz = 2'b00;
				next_s.pend = 1'b0;
				next_s.tmo_run = 1'b0;
				next_s.chk_run = 1'b1;
				next_s.chk = '0;
			end
		end
		if (s.chk_run) begin
			if (s.chk == CHK_W'(CHK_CYC - 1)) begin
				next_s.chk_run = 1'b0;
				if (!(|oc_raw)) begin
					next_s.oc_stat = 1'b0;
				end
			end else begin
				next_s.chk = s.chk + 1'b1;
			end
		end
		if (pin_edge) begin
			next_s.fault_pin_n_low = 1'b0;
		end
		// A new trip overrides any clear in the same cycle.
		if (|trip) begin
			next_s.hiz = s.hiz | (half_bridge ? trip : 2'b11);
			next_s.oc_stat = 1'b1;
			next_s.fault_pin_n_low = 1'b1;
			next_s.tmo_run = 1'b1;
			next_s.tmo = '0;
			next_s.chk_run = 1'b0;
			next_s.pend = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign hiz = s.hiz;
	assign oc_stat = s.oc_stat;
	assign fault_pin_n_low = s.fault_pin_n_low;

endmodule
`default_nettype wire

// >>> core/bfdr_top.sv
// Fault supervision and recovery for a dual-channel H-bridge driver.
// Assumes all pin and sensor inputs are synchronous to clk, and an APB
// master on the register side.
`timescale 1ns/1ps
`default_nettype none
module bfdr_top #(
	parameter int TMO_CYC = bfdr_pkg::RECOV_TMO_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [bfdr_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Enable pins, per channel
	input wire logic [1:0] drive_enable_high,
	input wire logic [1:0] drive_enable_low_n,
	// Duty-on points of the serial-set PWM generator, per channel
	input wire logic [1:0] duty_on,
	// Fault sensors
	input wire logic [3:0] oc_raw,
	input wire logic thermal_shutdown,
	input wire logic [1:0] open_load,
	input wire logic vbat_uv,
	input wire logic vcc_uv,
	// Bridge and fault pins; bit 0 is bridge_out_a up to bit 3 bridge_out_d
	output logic [3:0] bridge_out_hiz,
	output logic [1:0] fault_pin_n
);
	import bfdr_pkg::*;

	typedef struct packed {
		bfdr_ctrl_t ctrl;
		logic lvuv;
		logic [1:0] en_prev;
		logic [1:0] enb_prev;
		logic [1:0] rel;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [3:0] hiz;
		logic [1:0] fault_n;
	} bfdr_top_t;

	bfdr_top_t s;
	bfdr_top_t next_s;
	logic [1:0] enabled;
	logic [1:0] was_enabled;
	logic [1:0] en_edge;
	logic [1:0] pin_edge;
	logic [1:0] ch_oc;
	logic [1:0] ch_fault_pin_n;
	logic [3:0] ch_hiz;
	logic supply_uv;
	logic access;
	bfdr_reg_t sel;
	logic [31:0] stat_word;

	function automatic bfdr_reg_t reg_of(input logic [ADDR_W-1:0] a);
		unique case (a)
			CTRL_OFS: reg_of = BFDR_REG_CTRL;
			STAT_OFS: reg_of = BFDR_REG_STAT;
			REL_OFS: reg_of = BFDR_REG_REL;
			default: reg_of = BFDR_REG_NONE;
		endcase
	endfunction

	assign enabled = drive_enable_high & ~drive_enable_low_n;
	assign was_enabled = s.en_prev & ~s.enb_prev;
	assign en_edge = enabled & ~was_enabled;
	assign pin_edge = (drive_enable_high & ~s.en_prev) |
		(~drive_enable_low_n & s.enb_prev);
	assign supply_uv = vbat_uv | vcc_uv;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_chan
			bfdr_chan #(
				.TMO_CYC(TMO_CYC)
			) u_chan (
				.clk(clk),
				.rst(rst),
				.latched_mode(s.ctrl.latched),
				.spi_pwm(s.ctrl.spi_pwm[g]),
				.half_bridge(s.ctrl.half_bridge),
				.oc_raw(oc_raw[2*g+1:2*g]),
				.enabled(enabled[g]),
				.en_edge(en_edge[g]),
				.pin_edge(pin_edge[g]),
				.rel_cmd(s.rel[g]),
				.duty_on(duty_on[g]),
				.hiz(ch_hiz[2*g+1:2*g]),
				.oc_stat(ch_oc[g]),
				.fault_pin_n_low(ch_fault_pin_n[g])
			);
		end
	endgenerate

	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[STAT_OC0] = ch_oc[0];
		stat_word[STAT_OC1] = ch_oc[1];
		stat_word[STAT_OT] = thermal_shutdown;
		stat_word[STAT_VBAT_UV] = vbat_uv;
		stat_word[STAT_VCC_UV] = vcc_uv;
		stat_word[STAT_OPEN0] = open_load[0];
		stat_word[STAT_OPEN1] = open_load[1];
		stat_word[STAT_LVUV] = s.lvuv;
	end

	always_comb begin
		next_s = s;
		sel = reg_of(paddr);
		access = psel && penable && s.pready;
		next_s.en_prev = drive_enable_high;
		next_s.enb_prev = drive_enable_low_n;
		next_s.rel = 2'b00;
		// One wait state lets read data come from a flip-flop.
		next_s.pready = psel && penable && !s.pready;
		if (psel && penable && !s.pready) begin
			next_s.pslverr = (sel == BFDR_REG_NONE);
			next_s.prdata = 32'h0000_0000;
			if (!pwrite) begin
				unique case (sel)
					BFDR_REG_CTRL: begin
						next_s.prdata[CTRL_LATCHED] = s.ctrl.latched;
						next_s.prdata[CTRL_SPI_PWM0] = s.ctrl.spi_pwm[0];
						next_s.prdata[CTRL_SPI_PWM1] = s.ctrl.spi_pwm[1];
						next_s.prdata[CTRL_HALF] = s.ctrl.half_bridge;
					end
					BFDR_REG_STAT: next_s.prdata = stat_word;
					default: next_s.prdata = 32'h0000_0000;
				endcase
			end
		end else if (access) begin
			next_s.pslverr = 1'b0;
		end
		if (access && pwrite) begin
			unique case (sel)
				BFDR_REG_CTRL: begin
					// Fields follow the package bit positions, not the
					// packing order of the struct.
					next_s.ctrl.latched = pwdata[CTRL_LATCHED];
					next_s.ctrl.spi_pwm = {pwdata[CTRL_SPI_PWM1],
						pwdata[CTRL_SPI_PWM0]};
					next_s.ctrl.half_bridge = pwdata[CTRL_HALF];
				end
				BFDR_REG_REL: next_s.rel = pwdata[1:0];
				BFDR_REG_STAT: begin
					if (pwdata[STAT_LVUV]) begin
						next_s.lvuv = 1'b0;
					end
				end
				default: next_s.rel = 2'b00;
			endcase
		end
		if (|en_edge) begin
			next_s.lvuv = 1'b0;
		end
		// A live VCC under-voltage wins over any clear in the same cycle.
		if (vcc_uv) begin
			next_s.lvuv = 1'b1;
		end
		// Supply and thermal faults release by themselves as they clear.
		next_s.hiz = ch_hiz | {{2{~enabled[1]}}, {2{~enabled[0]}}} |
			{4{thermal_shutdown | supply_uv}};
		for (int i = 0; i < 2; i++) begin
			next_s.fault_n[i] = !(ch_fault_pin_n[i] | thermal_shutdown |
				supply_uv | (|open_load));
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.ctrl <= CTRL_RST;
			s.hiz <= 4'hF;
			s.fault_n <= 2'b00;
			s.enb_prev <= 2'b11;
		end else begin
			s <= next_s;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign bridge_out_hiz = s.hiz;
	assign fault_pin_n = s.fault_n;

endmodule
`default_nettype wire

// >>> dv/bfdr_properties.sv
// Port checker for the bridge fault supervisor.
// Bound into bfdr_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module bfdr_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// Pins and sensors
	input wire logic [1:0] drive_enable_high,
	input wire logic [1:0] drive_enable_low_n,
	input wire logic [3:0] oc_raw,
	input wire logic thermal_shutdown,
	input wire logic [1:0] open_load,
	input wire logic vbat_uv,
	input wire logic vcc_uv,
	input wire logic [3:0] bridge_out_hiz,
	input wire logic [1:0] fault_pin_n
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// The run saturates so a stuck comparator does not wrap and re-fire.
	logic [4:0] run_a;
	wire logic all_off = bridge_out_hiz == 4'hF && fault_pin_n == 2'h0;
	wire logic en_a = drive_enable_high[0] && !drive_enable_low_n[0];
	wire logic en_c = drive_enable_high[1] && !drive_enable_low_n[1];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run_a <= 5'h0;
		end else begin
			run_a <= oc_raw[0] ? run_a + 5'(run_a != 5'h1F) : 5'h0;
		end
	end
	sequence s_setup;
		psel && !penable ##1 psel && penable;
	endsequence
	sequence s_trip_a;
		run_a == 5'h18 && oc_raw[0];
	endsequence
	sequence s_shut_a;
		##[1:3] (bridge_out_hiz[0] && !fault_pin_n[0]);
	endsequence
	a_apb_wait: assert property (s_setup |-> !pready ##1 pready)
		else $error("APB answer timing wrong");
	a_stray_ready: assert property (!(psel && penable) |-> !pready)
		else $error("pready outside an access");
	a_oc_trip: assert property (s_trip_a |-> s_shut_a)
		else $error("over-current did not trip channel 0");
	a_temp_off: assert property (thermal_shutdown |=> all_off)
		else $error("over-temperature did not shut down");
	a_uv_off: assert property (vbat_uv || vcc_uv |=> all_off)
		else $error("under-voltage did not shut down");
	a_open_pins: assert property (|open_load |=> !fault_pin_n)
		else $error("open load did not pull fault pins");
	a_dis_a: assert property (!en_a |=> &bridge_out_hiz[1:0])
		else $error("disabled channel 0 still driving");
	a_dis_c: assert property (!en_c |=> &bridge_out_hiz[3:2])
		else $error("disabled channel 1 still driving");
endmodule
bind bfdr_top bfdr_properties u_props (.*);
`default_nettype wire

// >>> dv/bfdr_host.sv
// Host model of the enable pins of both channels.
// Requests come from the bench at rising clock edges.
`timescale 1ns/1ps
`default_nettype none
module bfdr_host (
	// Requests
	input wire logic [1:0] en,
	input wire logic [1:0] use_low,
	// Enable pins
	output logic [1:0] drive_enable_high,
	output logic [1:0] drive_enable_low_n
);
	// Each channel disables through one pin only, so both edge kinds occur.
	assign drive_enable_high = en | use_low;
	assign drive_enable_low_n = ~en & use_low;
endmodule
`default_nettype wire

// >>> dv/bfdr_top_tb.sv
// Bench for bfdr_top: APB tasks, fault stimulus and port checks.
// Uses the host enable model and a 200-cycle recovery timeout.
`timescale 1ns/1ps
`default_nettype none
module bfdr_top_tb;
	import bfdr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, er;
	logic [1:0] en = 2'h3, use_low = 2'h1, en_hi, en_lo_n, duty = '0;
	logic [3:0] oc = '0, flt = '0, hiz;
	logic [1:0] pin_n;
	wire logic [31:0] ob = {26'h0, pin_n, hiz};
	int failures = 0;
	int num_checks = 0;
	int n;
	bfdr_host host (.en(en), .use_low(use_low),
		.drive_enable_high(en_hi), .drive_enable_low_n(en_lo_n));
	bfdr_top #(.TMO_CYC(200)) uut (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .drive_enable_high(en_hi),
		.drive_enable_low_n(en_lo_n), .duty_on(duty), .oc_raw(oc),
		.thermal_shutdown(flt[0]), .vbat_uv(flt[1]), .vcc_uv(flt[2]),
		.open_load({2{flt[3]}}), .bridge_out_hiz(hiz),
		.fault_pin_n(pin_n));
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic end_of_test();
		if (failures == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	// Ends the run when a wait uses up its bound.
	task automatic give_up();
		failures++;
		end_of_test();
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) give_up();
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic trip(input int b, input int k);
		@(posedge clk);
		oc[b] <= 1'b1;
		cyc(k);
		oc[b] <= 1'b0;
		cyc(3);
	endtask
	task automatic pulse_en(input int c);
		en[c] <= 1'b0;
		cyc(3);
		en[c] <= 1'b1;
		cyc(3);
	endtask
	initial begin
		cyc(8);
		rst <= 1'b0;
		apb(1'b0, CTRL_OFS, 32'h0);
		chk("ctrl", rd, 32'h0);
		apb(1'b0, 8'h0C, 32'h0);
		chk("err", {31'h0, er}, 32'h1);
		chk("bad", rd, 32'h0);
		trip(0, 24);
		chk("filt", ob, 32'h30);
		trip(0, 25);
		chk("trip", ob, 32'h23);
		apb(1'b0, STAT_OFS, 32'h0);
		chk("oc", rd, 32'h1);
		cyc(140);
		chk("early", ob, 32'h23);
		n = 0;
		while (hiz !== 4'h0 && n < 100) begin
			cyc(1);
			n++;
		end
		if (n >= 100) give_up();
		cyc(90);
		chk("pin", ob, 32'h20);
		apb(1'b0, STAT_OFS, 32'h0);
		chk("rchk", rd, 32'h0);
		pulse_en(0);
		chk("pinc", ob, 32'h30);
		apb(1'b1, CTRL_OFS, 32'h1);
		trip(2, 25);
		cyc(250);
		chk("latch", ob, 32'h1C);
		en[1] <= 1'b0;
		apb(1'b0, STAT_OFS, 32'h0);
		chk("dis", rd, 32'h2);
		en[1] <= 1'b1;
		cyc(3);
		chk("en", ob, 32'h30);
		apb(1'b1, CTRL_OFS, 32'h3);
		apb(1'b0, CTRL_OFS, 32'h0);
		chk("ctrl3", rd, 32'h3);
		trip(0, 25);
		apb(1'b1, REL_OFS, 32'h1);
		cyc(5);
		chk("wait", ob, 32'h23);
		duty[0] <= 1'b1;
		cyc(1);
		duty[0] <= 1'b0;
		cyc(3);
		chk("duty", ob, 32'h20);
		pulse_en(0);
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, CTRL_OFS, i ? 32'h9 : 32'h1);
			trip(i, 25);
			chk("trip", ob, i ? 32'h22 : 32'h23);
			apb(1'b1, REL_OFS, 32'h1);
			cyc(3);
			chk("rel", ob, 32'h20);
			pulse_en(0);
		end
		apb(1'b1, CTRL_OFS, 32'h0);
		for (int i = 0; i < 4; i++) begin
			flt <= 4'h1 << i;
			cyc(3);
			chk("flt", ob, i == 3 ? 32'h0 : 32'hF);
			flt <= 4'h0;
			cyc(3);
			chk("back", ob, 32'h30);
		end
		// Let the last release's re-check finish before reading status.
		cyc(90);
		apb(1'b0, STAT_OFS, 32'h0);
		chk("uv", rd, 32'h400);
		apb(1'b1, STAT_OFS, 32'h400);
		apb(1'b0, STAT_OFS, 32'h0);
		chk("w1c", rd, 32'h0);
		flt <= 4'h4;
		cyc(3);
		flt <= 4'h0;
		cyc(3);
		pulse_en(1);
		apb(1'b0, STAT_OFS, 32'h0);
		chk("enc", rd, 32'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
